// ==== rtl/swcan_wake_sleep_inhibit_ctrl.sv ====
// Power-state sequencer, regulator enable and bus driver gating
// Operation
// - After power-on reset the block sits in standby with the regulator enable high.
// - In standby, a mode that stays sleep for the whole timeout returns to sleep, enable low.
// - A wake-up pulse on the high-voltage wake-up input raises the regulator enable again.
// - A wake-up restarts the standby sequence and rearms the timeout from zero.
// - Any active mode stops the timer and keeps the regulator enable high.
// - Selecting sleep with no wake-up present drops the enable after the timeout.
// - Loss of ground opens the load ground switch while bus transmission goes on.
// - After loss of ground the driver still stops when undervoltage lockout or overtemperature shutdown fires, or when the block enters sleep.
// - Overtemperature shutdown disables the high-side bus driver.
// - High-speed mode switches edge shaping off.
// - Normal and high-voltage wake-up modes switch edge shaping on.
// - Mode a alone is high-speed, b alone is wake-up, both is normal, none is sleep.
// - Any mode other than both-low leaves sleep.
// - A high-voltage wake-up from sleep drives the receive output low as an interrupt.
// - In sleep the bus driver is never dominant whatever the transmit input.
`timescale 1ns/1ns
`include "swcan_ctrl_defines.svh"
module swcan_wake_sleep_inhibit_ctrl
    import swcan_ctrl_pkg::*;
#(
    // Tick divider; a small value lets a test reach the timeout
    parameter int unsigned TICK_DIV = `TICK_DIV_CYC
)
(
    input  wire logic i_sys_clk,
    input  wire logic i_rst_n,
    input  wire logic i_mode_select_a,
    input  wire logic i_mode_select_b,
    input  wire logic i_high_voltage_wakeup,
    input  wire logic i_tx_dominant_n,
    input  wire logic i_bus_rx_dominant,
    input  wire logic i_loss_of_ground,
    input  wire logic i_undervoltage,
    input  wire logic i_overtemp,
    output logic      o_regulator_enable_out,
    output logic      o_load_switch_on,
    output logic      o_bus_driver_out,
    output logic      o_edge_shaping_en,
    output logic      o_high_voltage_drive,
    output logic      o_rx_n,
    output logic      o_rx_oe,
    output logic      o_sleep_state
);
    pwr_state_type            state_r;
    pwr_state_type            state_nxt;
    logic [1:0]               mode_sync;
    logic [1:0]               mode_r;
    logic                     mode_changed;
    logic [`TICK_CNT_W-1:0]   tick_cnt_r;
    logic                     tick;
    logic [`TMO_CNT_W-1:0]    tmo_cnt_r;
    logic                     tmo_done;
    logic                     wake_irq_r;
    logic                     lgnd_latched_r;

    swcan_mode_sync u_mode_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_async   ({i_mode_select_b, i_mode_select_a}),
        .o_sync    (mode_sync)
    );

    // Previous decoded mode, to see a change while in standby
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_r <= `MODE_SLEEP;
        end else begin
            mode_r <= mode_sync;
        end
    end
    assign mode_changed = (mode_sync != mode_r);

    // Slow tick keeps the timeout counter narrow
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_cnt_r <= '0;
        end else if (tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
        end
    end
    assign tick = (tick_cnt_r == `TICK_CNT_W'(TICK_DIV - 1));

    // Timeout runs only in standby; any other state or a wake-up rearms it
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tmo_cnt_r <= '0;
        end else if (state_r != ST_STANDBY || i_high_voltage_wakeup || mode_changed) begin
            tmo_cnt_r <= '0;
        end else if (tick && !tmo_done) begin
            tmo_cnt_r <= tmo_cnt_r + 1'b1;
        end
    end
    assign tmo_done = (tmo_cnt_r == `TMO_CNT_W'(`SLEEP_TIMEOUT_TICKS));

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_SLEEP: begin
                if (mode_sync != `MODE_SLEEP) begin
                    state_nxt = ST_ACTIVE;
                end else if (i_high_voltage_wakeup) begin
                    state_nxt = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (mode_sync != `MODE_SLEEP) begin
                    state_nxt = ST_ACTIVE;
                end else if (tmo_done && !i_high_voltage_wakeup) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_ACTIVE: begin
                if (mode_sync == `MODE_SLEEP) begin
                    state_nxt = ST_STANDBY;
                end
            end
            default: state_nxt = ST_STANDBY;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= ST_STANDBY;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Wake interrupt held until the host selects a mode or sleep returns
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wake_irq_r <= 1'b0;
        end else if (state_r == ST_SLEEP && state_nxt == ST_STANDBY) begin
            wake_irq_r <= 1'b1;
        end else if (state_r != ST_STANDBY) begin
            wake_irq_r <= 1'b0;
        end
    end

    // Loss of ground latched until reset; it releases only with the supply
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lgnd_latched_r <= 1'b0;
        end else if (i_loss_of_ground) begin
            lgnd_latched_r <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_regulator_enable_out <= 1'b1;
            o_load_switch_on       <= 1'b1;
            o_bus_driver_out       <= 1'b0;
            o_edge_shaping_en      <= 1'b1;
            o_high_voltage_drive   <= 1'b0;
            o_rx_n                 <= 1'b1;
            o_rx_oe                <= 1'b0;
            o_sleep_state          <= 1'b0;
        end else begin
            o_regulator_enable_out <= (state_nxt != ST_SLEEP);
            o_load_switch_on       <= !(lgnd_latched_r || i_loss_of_ground);
            o_bus_driver_out       <= (state_nxt != ST_SLEEP) && !i_tx_dominant_n
                                      && !i_undervoltage && !i_overtemp;
            o_edge_shaping_en      <= (mode_sync != `MODE_HIGH_SPEED);
            o_high_voltage_drive   <= (mode_sync == `MODE_HV_WAKEUP);
            o_rx_n                 <= (state_nxt == ST_ACTIVE) ? !i_bus_rx_dominant
                                      : !(wake_irq_r ||
                                          (state_r == ST_SLEEP && state_nxt == ST_STANDBY));
            o_rx_oe                <= (state_nxt != ST_SLEEP);
            o_sleep_state          <= (state_nxt == ST_SLEEP);
        end
    end

    sequence s_standby_idle;
        state_r == ST_STANDBY && mode_sync == `MODE_SLEEP && !i_high_voltage_wakeup;
    endsequence

    a_timeout_to_sleep: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (s_standby_idle and tmo_done) |=> !o_regulator_enable_out)
        else $error("regulator enable not dropped after timeout");
    a_wake_enable: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        state_r == ST_SLEEP && i_high_voltage_wakeup |=> o_regulator_enable_out)
        else $error("wake-up did not raise regulator enable");
    a_wake_rearm: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        state_r == ST_SLEEP && i_high_voltage_wakeup && mode_sync == `MODE_SLEEP
        |=> state_r == ST_STANDBY && tmo_cnt_r == '0)
        else $error("wake-up did not restart standby");
    a_active_holds: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        state_r == ST_ACTIVE |-> tmo_cnt_r == '0 && o_regulator_enable_out)
        else $error("timer running or enable low in active mode");
    a_leave_sleep: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        state_r == ST_SLEEP && mode_sync != `MODE_SLEEP |=> state_r == ST_ACTIVE)
        else $error("mode change did not leave sleep");
    a_sleep_no_drive: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_sleep_state |-> !o_bus_driver_out)
        else $error("bus driven dominant in sleep");
    a_lgnd_open: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_loss_of_ground |=> !o_load_switch_on)
        else $error("load switch not opened on loss of ground");
    a_uv_stop: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_undervoltage || i_overtemp |=> !o_bus_driver_out)
        else $error("driver on during undervoltage or overtemperature");
    a_shaping_mode: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ##1 o_edge_shaping_en == ($past(mode_sync) != `MODE_HIGH_SPEED))
        else $error("edge shaping does not follow mode");
    a_wake_irq: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        state_r == ST_SLEEP && i_high_voltage_wakeup && mode_sync == `MODE_SLEEP
        |=> !o_rx_n && o_rx_oe)
        else $error("wake interrupt not signalled on receive output");
endmodule // swcan_wake_sleep_inhibit_ctrl

// ==== rtl/swcan_ctrl_defines.svh ====
// Constants for the single-wire bus power-state controller
`ifndef SWCAN_CTRL_DEFINES_SVH
`define SWCAN_CTRL_DEFINES_SVH
`define CLK_FREQ_HZ          50_000_000
`define SLEEP_TIMEOUT_MS     250
`define SLEEP_TIMEOUT_CYC    ((`CLK_FREQ_HZ / 1000) * `SLEEP_TIMEOUT_MS)
`define TICK_DIV_CYC         50_000
`define SLEEP_TIMEOUT_TICKS  (`SLEEP_TIMEOUT_CYC / `TICK_DIV_CYC)
`define TICK_CNT_W           16
`define TMO_CNT_W            16
`define MODE_SLEEP           2'b00
`define MODE_HIGH_SPEED      2'b01
`define MODE_HV_WAKEUP       2'b10
`define MODE_NORMAL          2'b11
`endif

// ==== rtl/swcan_ctrl_pkg.sv ====
// Types for the single-wire bus power-state controller
package swcan_ctrl_pkg;
    typedef enum logic [2:0] {
        ST_SLEEP   = 3'b001,
        ST_STANDBY = 3'b010,
        ST_ACTIVE  = 3'b100
    } pwr_state_type;
endpackage

// ==== rtl/swcan_mode_sync.sv ====
// Two-flop synchroniser for the two mode-select inputs
`timescale 1ns/1ns
module swcan_mode_sync (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic [1:0] i_async,
    output logic      [1:0] o_sync
);
    logic [1:0] meta_r;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_bit
            always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    meta_r[g] <= 1'b0;
                    o_sync[g] <= 1'b0;
                end else begin
                    meta_r[g] <= i_async[g];
                    o_sync[g] <= meta_r[g];
                end
            end
        end
    endgenerate
endmodule // swcan_mode_sync

// ==== bench/host_model.sv ====
// Host controller model driving the mode pins and transmit line
`timescale 1ns/1ns
module host_model (
    input  wire logic       i_sys_clk,
    input  wire logic [1:0] i_mode_req,
    input  wire logic       i_tx_req,
    output logic            o_mode_select_a,
    output logic            o_mode_select_b,
    output logic            o_tx_dominant_n
);
    // Pulldown level until first edge, so sleep is selected
    initial begin
        o_mode_select_a = 1'b0;
        o_mode_select_b = 1'b0;
        o_tx_dominant_n = 1'b1;
    end
    // Port register: pins only move just after an edge
    always @(posedge i_sys_clk) begin
        o_mode_select_a <= i_mode_req[0];
        o_mode_select_b <= i_mode_req[1];
        o_tx_dominant_n <= ~i_tx_req;
    end
endmodule // host_model

// ==== bench/testbench.sv ====
// Self-checking bench for the power-state controller
`timescale 1ns/1ns
`include "swcan_ctrl_defines.svh"
module testbench;
    // Short tick divider so the sleep timeout fits the run
    localparam int TDIV    = 4;
    localparam int TMO_CYC = `SLEEP_TIMEOUT_TICKS * TDIV;
    logic       i_sys_clk = 1'b0;
    logic       i_rst_n   = 1'b0;
    logic [1:0] mode_req  = 2'b00;
    logic       tx_req    = 1'b0;
    logic       wake      = 1'b0;
    logic       bus_rx    = 1'b0;
    logic       lgnd      = 1'b0;
    logic       uvolt     = 1'b0;
    logic       otemp     = 1'b0;
    logic       mode_a, mode_b, tx_n;
    logic       reg_en, load_on, drv, shape, hv_drv, rx_n, rx_oe, sleep_st;
    int         bad_count   = 0;
    int         check_count = 0;
    int         cycles      = 0;

    always #10 i_sys_clk = ~i_sys_clk;

    host_model host (.i_sys_clk(i_sys_clk), .i_mode_req(mode_req), .i_tx_req(tx_req),
        .o_mode_select_a(mode_a), .o_mode_select_b(mode_b), .o_tx_dominant_n(tx_n));

    swcan_wake_sleep_inhibit_ctrl #(.TICK_DIV(TDIV)) dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_mode_select_a(mode_a), .i_mode_select_b(mode_b),
        .i_high_voltage_wakeup(wake), .i_tx_dominant_n(tx_n), .i_bus_rx_dominant(bus_rx),
        .i_loss_of_ground(lgnd), .i_undervoltage(uvolt), .i_overtemp(otemp),
        .o_regulator_enable_out(reg_en), .o_load_switch_on(load_on),
        .o_bus_driver_out(drv), .o_edge_shaping_en(shape), .o_high_voltage_drive(hv_drv),
        .o_rx_n(rx_n), .o_rx_oe(rx_oe), .o_sleep_state(sleep_st));

    task automatic check(input logic seen, input logic exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen %b expected %b", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
    endtask

    function automatic logic drive_exp(input logic tx, input logic uv, input logic ot);
        return tx & ~uv & ~ot;
    endfunction

    // Whole run needs about 4200 cycles
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    initial begin
        void'($urandom(95199));
        @(negedge i_sys_clk);
        check(reg_en, 1'b1);
        check(load_on, 1'b1);
        check(drv, 1'b0);
        check(sleep_st, 1'b0);
        @(posedge i_sys_clk);
        @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            @(posedge i_sys_clk);
            mode_req <= 2'(m);
            wait_cyc(6);
            check(shape, 1'(m != 1));
            check(hv_drv, 1'(m == 2));
            check(reg_en, 1'b1);
            check(sleep_st, 1'b0);
        end
        // Normal mode; wake-ups while active must change nothing
        repeat (200) begin
            @(posedge i_sys_clk);
            tx_req <= 1'($urandom_range(1));
            bus_rx <= 1'($urandom_range(1));
            wake   <= 1'($urandom_range(1));
            uvolt  <= 1'($urandom_range(7) == 0);
            otemp  <= 1'($urandom_range(7) == 0);
            wait_cyc(2);
            check(drv, drive_exp(tx_req, uvolt, otemp));
            check(reg_en, 1'b1);
            check(rx_n, ~bus_rx);
            check(rx_oe, 1'b1);
            check(load_on, 1'b1);
        end
        @(posedge i_sys_clk);
        {wake, uvolt, otemp, tx_req, lgnd} <= 5'b0_0011;
        wait_cyc(3);
        check(load_on, 1'b0);
        check(drv, 1'b1);
        @(posedge i_sys_clk);
        uvolt <= 1'b1;
        wait_cyc(2);
        check(drv, 1'b0);
        check(load_on, 1'b0);
        // Second reset clears the latched ground fault, then idle in standby
        @(posedge i_sys_clk);
        {i_rst_n, lgnd, uvolt, tx_req, mode_req} <= 6'b0_0000_0;
        wait_cyc(2);
        check(load_on, 1'b1);
        @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        // Tick phase is fixed by the reset, so both end points are exact here
        wait_cyc(TMO_CYC);
        check(reg_en, 1'b1);
        wait_cyc(1);
        check(reg_en, 1'b0);
        check(sleep_st, 1'b1);
        check(rx_oe, 1'b0);
        @(posedge i_sys_clk);
        tx_req <= 1'b1;
        wait_cyc(4);
        check(drv, 1'b0);
        check(reg_en, 1'b0);
        // Wake-up pulse from sleep, then a second one halfway through standby
        repeat (2) begin
            @(posedge i_sys_clk);
            wake <= 1'b1;
            @(posedge i_sys_clk);
            wake <= 1'b0;
            @(negedge i_sys_clk);
            check(reg_en, 1'b1);
            check(rx_n, 1'b0);
            check(rx_oe, 1'b1);
            check(sleep_st, 1'b0);
            wait_cyc(TMO_CYC / 2);
        end
        // Tick phase now free: allow a few cycles either side
        wait_cyc(TMO_CYC / 2 - 4);
        check(reg_en, 1'b1);
        check(rx_n, 1'b0);
        wait_cyc(6);
        check(reg_en, 1'b0);
        check(sleep_st, 1'b1);
        // Mode pins leave sleep, then selecting sleep runs the timeout again
        @(posedge i_sys_clk);
        mode_req <= 2'b11;
        wait_cyc(6);
        check(reg_en, 1'b1);
        check(sleep_st, 1'b0);
        check(drv, 1'b1);
        @(posedge i_sys_clk);
        mode_req <= 2'b00;
        wait_cyc(TMO_CYC - 4);
        check(reg_en, 1'b1);
        wait_cyc(10);
        check(reg_en, 1'b0);
        check(sleep_st, 1'b1);
        tally_and_finish();
    end
endmodule // testbench
